/* File: include/hbsi_defs.svh */
// constants for the host bus slave port: lane patterns, decode and reset values
`ifndef HBSI_DEFS_SVH
`define HBSI_DEFS_SVH
// 32-bit lane patterns, bit i is the active-low enable of byte lane i
`define HBSI_BE_DWORD    4'h0
`define HBSI_BE_LOWORD   4'hC
`define HBSI_BE_HIWORD   4'h3
`define HBSI_BE_BYTE0    4'hE
`define HBSI_BE_BYTE1    4'hD
`define HBSI_BE_BYTE2    4'hB
`define HBSI_BE_BYTE3    4'h7
// 16-bit lane patterns, bit 0 from address bit 0, bit 1 from high-byte enable
`define HBSI_ISA_BOTH    2'h0
`define HBSI_ISA_LOW     2'h2
`define HBSI_ISA_HIGH    2'h1
// i/o decode window on address bits 15..4
`define HBSI_IO_BASE     12'h030
`define HBSI_MEM_AW      4
// reset values
`define HBSI_NO_LANES4   4'h0
`define HBSI_NO_LANES2   2'h0
`define HBSI_ZERO32      32'h0000_0000
`define HBSI_ZERO16      16'h0000
`define HBSI_ZERO8       8'h00
`endif

/* File: include/hbsi_pkg.sv */
// types shared by the host bus slave port
package hbsi_pkg;
    typedef logic [3:0] hbsi_lanes_t;
    typedef enum logic {HBSI_MODE_LOCAL, HBSI_MODE_ISA} hbsi_mode_e;
    typedef enum logic [1:0] {LB_IDLE, LB_BUSY, LB_DONE} hbsi_lb_state_e;
endpackage

/* File: src/hbsi_word_mem.sv */
// small word memory behind the host port, byte-lane writes, registered read
`include "hbsi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module hbsi_word_mem #(
    parameter int AW = 4
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    input  wire logic          en,
    input  wire logic [3:0]    we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    output var  logic [31:0]   rdata
);
    // one bank per byte lane: a single writer each, and idle lanes keep their data
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            logic [7:0] bank [0:(1<<AW)-1];
            always_ff @(posedge clk_sys) begin
                if (en && we[gi]) begin
                    bank[addr] <= wdata[gi*8 +: 8];
                end
            end
            // read data from a register, valid one cycle after the request
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    rdata[gi*8 +: 8] <= `HBSI_ZERO8;
                end else if (en) begin
                    rdata[gi*8 +: 8] <= bank[addr];
                end
            end
        end
    endgenerate
endmodule // hbsi_word_mem
`default_nettype wire

/* File: src/hbsi_host_port.sv */
// host bus slave port: synchronous 32-bit local bus and asynchronous 16-bit strobe bus
`include "hbsi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module hbsi_host_port #(
    parameter logic [11:0] IO_BASE = `HBSI_IO_BASE,
    parameter int          MEM_AW  = `HBSI_MEM_AW
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                bus_clock,
    input  wire logic                bus_mode_strap_n,
    input  wire logic [15:1]         addr_in,
    input  wire logic                io_qualifier_n,
    input  wire hbsi_pkg::hbsi_lanes_t byte_lane_sel_n,
    input  wire logic                addr_strobe_n,
    input  wire logic                cycle_strobe_n,
    input  wire logic                direction_write_high,
    input  wire logic                ready_return_n,
    input  wire logic                read_strobe_n,
    input  wire logic                write_strobe_n,
    input  wire logic [31:0]         data_in,
    output var  logic [31:0]         lb_data_out,
    output var  logic [3:0]          lb_data_oe,
    output var  logic                sync_ready_n,
    output var  logic [15:0]         isa_data_out,
    output var  logic [1:0]          isa_data_oe,
    output var  logic                async_ready,
    output var  logic                local_device_sel_n
);
    import hbsi_pkg::*;

    // active-high lane mask of a 32-bit pattern, empty when unsupported
    function automatic logic [3:0] lanes32(input logic [3:0] be);
        case (be)
            `HBSI_BE_DWORD, `HBSI_BE_LOWORD, `HBSI_BE_HIWORD,
            `HBSI_BE_BYTE0, `HBSI_BE_BYTE1, `HBSI_BE_BYTE2,
            `HBSI_BE_BYTE3: lanes32 = ~be;
            default:        lanes32 = `HBSI_NO_LANES4;
        endcase
    endfunction

    // active-high lane mask of a 16-bit pattern, empty when unsupported
    function automatic logic [1:0] lanes16(input logic [1:0] be);
        case (be)
            `HBSI_ISA_BOTH, `HBSI_ISA_LOW, `HBSI_ISA_HIGH: lanes16 = ~be;
            default: lanes16 = `HBSI_NO_LANES2;
        endcase
    endfunction

    // ==========================================================
    // strap capture in the system domain
    logic       strapM_q, strapS_q, strapDone_q, liveM_q, liveS_q;
    hbsi_mode_e mode_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strapM_q    <= 1'b0;
            strapS_q    <= 1'b0;
            strapDone_q <= 1'b0;
            liveM_q     <= 1'b0;
            liveS_q     <= 1'b0;
            mode_q      <= HBSI_MODE_LOCAL;
        end else begin
            strapM_q <= bus_mode_strap_n;
            strapS_q <= strapM_q;
            liveM_q  <= 1'b1;
            liveS_q  <= liveM_q;
            // caught once, after the pin has crossed both flops; a board level, not a switch
            if (liveS_q && !strapDone_q) begin
                strapDone_q <= 1'b1;
                mode_q      <= strapS_q ? HBSI_MODE_ISA : HBSI_MODE_LOCAL;
            end
        end
    end

    // ==========================================================
    // local bus side, all on bus clock rising edges
    logic           modeM_q, modeLb_q, latIoq_q, effIoq, lbHit, cycPrev_q;
    logic           reqT_q, reqWr_q, ackM_q, ackS_q, ackPrev_q, ackT_q;
    logic [15:2]    latAddr_q, effAddr, reqAddr_q;
    logic [3:0]     latBe_q, effBe, reqLanes_q;
    logic [31:0]    reqData_q, lbRd_q;
    hbsi_lb_state_e lbState_q;

    // local mode is a level from the system domain, two flops in
    always_ff @(posedge bus_clock or negedge rst_b) begin
        if (!rst_b) begin
            modeM_q  <= 1'b0;
            modeLb_q <= 1'b0;
        end else begin
            modeM_q  <= strapDone_q && (mode_q == HBSI_MODE_LOCAL);
            modeLb_q <= modeM_q;
        end
    end

    // address, qualifier and enables follow the pins while the strobe is low
    always_ff @(posedge bus_clock or negedge rst_b) begin
        if (!rst_b) begin
            latAddr_q <= '0;
            latBe_q   <= 4'hF;
            latIoq_q  <= 1'b1;
        end else if (!addr_strobe_n) begin
            latAddr_q <= addr_in[15:2];
            latBe_q   <= byte_lane_sel_n;
            latIoq_q  <= io_qualifier_n;
        end
    end

    // transparent view: live while strobe low, held value after its rising edge
    assign effAddr = addr_strobe_n ? latAddr_q : addr_in[15:2];
    assign effBe   = addr_strobe_n ? latBe_q : byte_lane_sel_n;
    assign effIoq  = addr_strobe_n ? latIoq_q : io_qualifier_n;
    assign lbHit   = !effIoq && (effAddr[15:4] == IO_BASE);

    // local cycle sequencer; the request bundle is frozen while the toggle is in flight
    always_ff @(posedge bus_clock or negedge rst_b) begin
        if (!rst_b) begin
            cycPrev_q    <= 1'b1;
            lbState_q    <= LB_IDLE;
            reqT_q       <= 1'b0;
            reqWr_q      <= 1'b0;
            reqAddr_q    <= '0;
            reqLanes_q   <= `HBSI_NO_LANES4;
            reqData_q    <= `HBSI_ZERO32;
            ackM_q       <= 1'b0;
            ackS_q       <= 1'b0;
            ackPrev_q    <= 1'b0;
            sync_ready_n <= 1'b1;
            lb_data_out  <= `HBSI_ZERO32;
            lb_data_oe   <= `HBSI_NO_LANES4;
        end else begin
            cycPrev_q    <= cycle_strobe_n;
            ackM_q       <= ackT_q;
            ackS_q       <= ackM_q;
            sync_ready_n <= 1'b1;
            case (lbState_q)
                LB_IDLE: begin
                    // first edge that sees the cycle strobe; glue delays it one clock
                    if (modeLb_q && !cycle_strobe_n && cycPrev_q && lbHit
                            && lanes32(effBe) != `HBSI_NO_LANES4) begin
                        reqWr_q    <= direction_write_high;
                        reqAddr_q  <= effAddr;
                        reqLanes_q <= lanes32(effBe);
                        reqData_q  <= data_in;
                        reqT_q     <= !reqT_q;
                        lbState_q  <= LB_BUSY;
                    end
                end
                LB_BUSY: begin
                    if (ackS_q != ackPrev_q) begin
                        ackPrev_q    <= ackS_q;
                        sync_ready_n <= 1'b0;
                        lb_data_out  <= lbRd_q;
                        lb_data_oe   <= reqWr_q ? `HBSI_NO_LANES4 : reqLanes_q;
                        lbState_q    <= LB_DONE;
                    end
                end
                LB_DONE: begin
                    // read data stays on the bus until the ready return closes the cycle
                    if (!ready_return_n || reqWr_q) begin
                        lb_data_oe <= `HBSI_NO_LANES4;
                        lbState_q  <= LB_IDLE;
                    end
                end
                default: lbState_q <= LB_IDLE;
            endcase
        end
    end

    // ==========================================================
    // strobe bus pins, two flops each before use
    logic        rdM_q, rdS_q, rdPrev_q, wrM_q, wrS_q, wrPrev_q;
    logic        ioqM_q, ioqS_q;
    logic [15:1] adM_q, adS_q;
    logic [1:0]  beM_q, beS_q;
    logic [15:0] dM_q, dS_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdM_q    <= 1'b1;
            rdS_q    <= 1'b1;
            rdPrev_q <= 1'b1;
            wrM_q    <= 1'b1;
            wrS_q    <= 1'b1;
            wrPrev_q <= 1'b1;
            ioqM_q   <= 1'b1;
            ioqS_q   <= 1'b1;
            adM_q    <= '0;
            adS_q    <= '0;
            beM_q    <= 2'h3;
            beS_q    <= 2'h3;
            dM_q     <= `HBSI_ZERO16;
            dS_q     <= `HBSI_ZERO16;
        end else begin
            rdM_q    <= read_strobe_n;
            rdS_q    <= rdM_q;
            rdPrev_q <= rdS_q;
            wrM_q    <= write_strobe_n;
            wrS_q    <= wrM_q;
            wrPrev_q <= wrS_q;
            ioqM_q   <= io_qualifier_n;
            ioqS_q   <= ioqM_q;
            adM_q    <= addr_in;
            adS_q    <= adM_q;
            beM_q    <= byte_lane_sel_n[1:0];
            beS_q    <= beM_q;
            dM_q     <= data_in[15:0];
            dS_q     <= dM_q;
        end
    end

    // device select from the decode; driven both ways, board adds open collector
    logic isaHit, isaMode;
    assign isaHit  = !ioqS_q && (adS_q[15:4] == IO_BASE);
    assign isaMode = strapDone_q && (mode_q == HBSI_MODE_ISA);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            local_device_sel_n <= 1'b1;
        end else begin
            local_device_sel_n <= !isaHit;
        end
    end

    // ==========================================================
    // memory access: local requests and strobe accesses never mix under one strap
    logic        reqM_q, reqS_q, reqPrev_q, lbPend_q;
    logic        isaPend_q, wrHeld_q, wrHi_q;
    logic [15:1] wrAddr_q;
    logic [1:0]  wrLanes_q;
    logic [15:0] wrData_q;
    logic        lbGo, rdGo, wrGo;
    logic        memEn;
    logic [3:0]  memWe;
    logic [MEM_AW-1:0] memAddr;
    logic [31:0] memWd, memRd;

    assign lbGo = (reqS_q != reqPrev_q);
    assign rdGo = isaMode && isaHit && !rdS_q && rdPrev_q;
    assign wrGo = isaMode && wrHeld_q && wrS_q && !wrPrev_q;

    // one access port; only decoded lanes are written
    always_comb begin
        memEn   = 1'b0;
        memWe   = `HBSI_NO_LANES4;
        memAddr = '0;
        memWd   = `HBSI_ZERO32;
        if (lbGo) begin
            memEn   = 1'b1;
            memWe   = reqWr_q ? reqLanes_q : `HBSI_NO_LANES4;
            memAddr = reqAddr_q[MEM_AW+1:2];
            memWd   = reqData_q;
        end else if (wrGo) begin
            memEn   = 1'b1;
            memWe   = wrHi_q ? {wrLanes_q, 2'h0} : {2'h0, wrLanes_q};
            memAddr = wrAddr_q[MEM_AW+1:2];
            memWd   = {wrData_q, wrData_q};
        end else if (rdGo) begin
            memEn   = 1'b1;
            memAddr = adS_q[MEM_AW+1:2];
        end
    end

    hbsi_word_mem #(.AW(MEM_AW)) u_mem (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .en      (memEn),
        .we      (memWe),
        .addr    (memAddr),
        .wdata   (memWd),
        .rdata   (memRd)
    );

    // local handshake: request toggle in, answer toggle out a cycle after the read
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reqM_q    <= 1'b0;
            reqS_q    <= 1'b0;
            reqPrev_q <= 1'b0;
            lbPend_q  <= 1'b0;
            ackT_q    <= 1'b0;
            lbRd_q    <= `HBSI_ZERO32;
        end else begin
            reqM_q    <= reqT_q;
            reqS_q    <= reqM_q;
            reqPrev_q <= reqS_q;
            lbPend_q  <= lbGo;
            if (lbPend_q) begin
                lbRd_q <= memRd;
                ackT_q <= !ackT_q;
            end
        end
    end

    // strobe side: writes post at the trailing edge, reads hold ready low until data
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            isaPend_q    <= 1'b0;
            wrHeld_q     <= 1'b0;
            wrHi_q       <= 1'b0;
            wrAddr_q     <= '0;
            wrLanes_q    <= `HBSI_NO_LANES2;
            wrData_q     <= `HBSI_ZERO16;
            async_ready  <= 1'b1;
            isa_data_out <= `HBSI_ZERO16;
            isa_data_oe  <= `HBSI_NO_LANES2;
        end else begin
            isaPend_q <= rdGo;
            // data keeps following the pins while the write strobe is low
            if (isaMode && !wrS_q) begin
                wrHeld_q  <= isaHit;
                wrHi_q    <= adS_q[1];
                wrAddr_q  <= adS_q;
                wrLanes_q <= lanes16(beS_q);
                wrData_q  <= dS_q;
            end else if (wrGo) begin
                wrHeld_q <= 1'b0;
            end
            if (rdGo) begin
                async_ready <= 1'b0;
            end else if (isaPend_q) begin
                async_ready  <= 1'b1;
                isa_data_out <= adS_q[1] ? memRd[31:16] : memRd[15:0];
                isa_data_oe  <= lanes16(beS_q);
            end else if (rdS_q) begin
                isa_data_oe <= `HBSI_NO_LANES2;
            end
        end
    end
endmodule // hbsi_host_port
`default_nettype wire

/* File: bench/hbsi_host_checker.sv */
// concurrent checks on the host bus slave port pins, bound to its top
`timescale 1ns/1ps
`default_nettype none
module hbsi_host_checker #(
    parameter logic [11:0] IO_BASE = 12'h030
) (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        bus_clock,
    input wire logic        bus_mode_strap_n,
    input wire logic [15:1] addr_in,
    input wire logic        io_qualifier_n,
    input wire logic [3:0]  byte_lane_sel_n,
    input wire logic        addr_strobe_n,
    input wire logic        cycle_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [3:0]  lb_data_oe,
    input wire logic        sync_ready_n,
    input wire logic [1:0]  isa_data_oe,
    input wire logic        async_ready,
    input wire logic        local_device_sel_n
);
    import hbsi_pkg::*;
    logic [6:0] missCnt;
    // ==========
    // local bus side
    // a refused cycle opens a window with no ready
    always_ff @(posedge bus_clock or negedge rst_b) begin
        if (!rst_b)
            missCnt <= 7'h00;
        else if ($fell(cycle_strobe_n) && io_qualifier_n)
            missCnt <= 7'h40;
        else if (missCnt != 7'h00)
            missCnt <= missCnt - 7'h01;
    end
    sequence s_lbHit;
        $fell(cycle_strobe_n) && !bus_mode_strap_n && !io_qualifier_n
            && addr_in[15:4] == IO_BASE
            && byte_lane_sel_n inside {4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7};
    endsequence
    property p_lbAnswer;
        @(posedge bus_clock) disable iff (!rst_b) s_lbHit |-> ##[2:60] !sync_ready_n;
    endproperty
    a_lbAnswer: assert property (p_lbAnswer) else $error("local cycle not answered");
    property p_lbMiss;
        @(posedge bus_clock) disable iff (!rst_b) missCnt != 7'h00 |-> sync_ready_n;
    endproperty
    a_lbMiss: assert property (p_lbMiss) else $error("ready on a refused cycle");
    property p_srdyPulse;
        @(posedge bus_clock) disable iff (!rst_b) !sync_ready_n |=> sync_ready_n;
    endproperty
    a_srdyPulse: assert property (p_srdyPulse) else $error("ready wider than one clock");
    property p_lbLanes;
        @(posedge bus_clock) disable iff (!rst_b)
            lb_data_oe != 4'h0 |-> lb_data_oe inside {4'hF, 4'h3, 4'hC, 4'h1, 4'h2, 4'h4, 4'h8};
    endproperty
    a_lbLanes: assert property (p_lbLanes) else $error("odd lane drive pattern");
    property p_lbStrap;
        @(posedge bus_clock) disable iff (!rst_b) bus_mode_strap_n [*8] |-> lb_data_oe == 4'h0;
    endproperty
    a_lbStrap: assert property (p_lbStrap) else $error("local lanes driven in strobe mode");
    // ==========
    // strobe bus side and device select
    property p_selMiss;
        @(posedge clk_sys) disable iff (!rst_b)
            (io_qualifier_n && !addr_strobe_n) [*5] |=> local_device_sel_n;
    endproperty
    a_selMiss: assert property (p_selMiss) else $error("select without qualifier");
    property p_selHit;
        @(posedge clk_sys) disable iff (!rst_b)
            (!io_qualifier_n && addr_in[15:4] == IO_BASE && !addr_strobe_n) [*5]
            |=> !local_device_sel_n;
    endproperty
    a_selHit: assert property (p_selHit) else $error("select missing on decode");
    property p_idleRdy;
        @(posedge clk_sys) disable iff (!rst_b)
            (read_strobe_n && write_strobe_n) [*8] |-> async_ready;
    endproperty
    a_idleRdy: assert property (p_idleRdy) else $error("ready low while idle");
    property p_rdyDrop;
        @(posedge clk_sys) disable iff (!rst_b)
            $fell(async_ready) |-> !read_strobe_n ##[1:4] async_ready;
    endproperty
    a_rdyDrop: assert property (p_rdyDrop) else $error("ready dip out of place");
    property p_isaOe;
        @(posedge clk_sys) disable iff (!rst_b) $rose(|isa_data_oe) |-> $rose(async_ready);
    endproperty
    a_isaOe: assert property (p_isaOe) else $error("read data apart from ready");
endmodule // hbsi_host_checker
bind hbsi_host_port hbsi_host_checker #(.IO_BASE(IO_BASE)) CHK (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus_clock(bus_clock),
    .bus_mode_strap_n(bus_mode_strap_n), .addr_in(addr_in), .io_qualifier_n(io_qualifier_n),
    .byte_lane_sel_n(byte_lane_sel_n), .addr_strobe_n(addr_strobe_n),
    .cycle_strobe_n(cycle_strobe_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .lb_data_oe(lb_data_oe), .sync_ready_n(sync_ready_n),
    .isa_data_oe(isa_data_oe), .async_ready(async_ready),
    .local_device_sel_n(local_device_sel_n)
);
`default_nettype wire

/* File: bench/hbsi_host_partner.sv */
// host bus model: local bus master with its glue, and strobe bus master
`timescale 1ns/1ps
`default_nettype none
module hbsi_host_partner (
    input  wire logic        clk_sys,
    output var  logic        bus_clock,
    output var  logic [15:1] addr_in,
    output var  logic        io_qualifier_n,
    output var  logic [3:0]  byte_lane_sel_n,
    output var  logic        addr_strobe_n,
    output var  logic        cycle_strobe_n,
    output var  logic        direction_write_high,
    output var  logic        ready_return_n,
    output var  logic        read_strobe_n,
    output var  logic        write_strobe_n,
    output var  logic [31:0] data_in,
    input  wire logic [31:0] lb_data_out,
    input  wire logic [3:0]  lb_data_oe,
    input  wire logic        sync_ready_n,
    input  wire logic [15:0] isa_data_out,
    input  wire logic [1:0]  isa_data_oe,
    input  wire logic        async_ready
);
    import hbsi_pkg::*;
    // free-running bus clock, offset phase
    initial begin
        bus_clock = 1'b0;
        #1.3;
        forever #3 bus_clock = ~bus_clock;
    end
    // idle levels; unused strobes parked
    task automatic set_mode(input logic isa);
        addr_strobe_n = ~isa;
        cycle_strobe_n = 1'b1;
        direction_write_high = 1'b1;
        ready_return_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr_in = '0;
        io_qualifier_n = 1'b1;
        byte_lane_sel_n = 4'hF;
        data_in = '0;
    endtask
    // one local cycle; pins scrambled once latched
    task automatic lb_cycle(input logic [15:1] a, input hbsi_lanes_t be, input logic wr, qn,
            input logic [31:0] d, output logic [31:0] rd, output logic [3:0] oe,
            output logic ok);
        ok = 1'b0;
        @(posedge bus_clock);
        #1;
        addr_strobe_n = 1'b0;
        addr_in = a;
        byte_lane_sel_n = be;
        io_qualifier_n = qn;
        direction_write_high = wr;
        data_in = d;
        @(posedge bus_clock);
        #1;
        addr_strobe_n = 1'b1;
        cycle_strobe_n = 1'b0;
        @(posedge bus_clock);
        #1;
        cycle_strobe_n = 1'b1;
        addr_in = ~a;
        byte_lane_sel_n = ~be;
        io_qualifier_n = ~qn;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge bus_clock);
            ok = (sync_ready_n === 1'b0);
        end
        rd = lb_data_out;
        oe = lb_data_oe;
        #1;
        ready_return_n = ~ok;
        @(posedge bus_clock);
        #1;
        ready_return_n = 1'b1;
        data_in = ~d;
    endtask
    // one strobe access; ready dips recorded
    task automatic isa_cycle(input logic [15:1] a, input logic [1:0] ln, input logic wr, qn,
            input logic [15:0] d, output logic [15:0] rd, output logic [1:0] oe,
            output logic drop);
        drop = 1'b0;
        @(posedge clk_sys);
        #1;
        addr_in = a;
        byte_lane_sel_n = {2'h3, ln};
        io_qualifier_n = qn;
        data_in = {16'hFFFF, d};
        @(posedge clk_sys);
        #1;
        read_strobe_n = wr;
        write_strobe_n = ~wr;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk_sys);
            drop = drop | (async_ready === 1'b0);
        end
        rd = isa_data_out;
        oe = isa_data_oe;
        #1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        data_in = ~data_in;
    endtask
endmodule // hbsi_host_partner
`default_nettype wire

/* File: bench/hbsi_host_port_tb_top.sv */
// self-checking bench for the host bus slave port
`timescale 1ns/1ps
`default_nettype none
module hbsi_host_port_tb_top;
    import hbsi_pkg::*;
    localparam logic [11:0] BASE = 12'h030;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        bus_mode_strap_n = 1'b0;
    logic        bus_clock, io_qualifier_n, addr_strobe_n, cycle_strobe_n, ok;
    logic        direction_write_high, ready_return_n, read_strobe_n, write_strobe_n;
    logic        sync_ready_n, async_ready, local_device_sel_n;
    logic [15:1] addr_in;
    logic [31:0] data_in, lb_data_out, rd32, seed;
    logic [31:0] shadow [4];
    logic [15:0] isa_data_out, rd16;
    logic [3:0]  lb_data_oe, oe4;
    logic [1:0]  isa_data_oe, oe2;
    hbsi_lanes_t byte_lane_sel_n;
    hbsi_lanes_t pats [8] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7, 4'h5};
    logic [1:0]  ipats [3] = '{2'h0, 2'h2, 2'h1};
    int          failCount = 0;
    int          nTests = 0;
    always #10 clk_sys = ~clk_sys;
    hbsi_host_port DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_clock(bus_clock),
        .bus_mode_strap_n(bus_mode_strap_n), .addr_in(addr_in), .io_qualifier_n(io_qualifier_n),
        .byte_lane_sel_n(byte_lane_sel_n), .addr_strobe_n(addr_strobe_n),
        .cycle_strobe_n(cycle_strobe_n), .direction_write_high(direction_write_high),
        .ready_return_n(ready_return_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .data_in(data_in), .lb_data_out(lb_data_out),
        .lb_data_oe(lb_data_oe), .sync_ready_n(sync_ready_n), .isa_data_out(isa_data_out),
        .isa_data_oe(isa_data_oe), .async_ready(async_ready),
        .local_device_sel_n(local_device_sel_n)
    );
    hbsi_host_partner PARTNER (
        .clk_sys(clk_sys), .bus_clock(bus_clock), .addr_in(addr_in),
        .io_qualifier_n(io_qualifier_n), .byte_lane_sel_n(byte_lane_sel_n),
        .addr_strobe_n(addr_strobe_n), .cycle_strobe_n(cycle_strobe_n),
        .direction_write_high(direction_write_high), .ready_return_n(ready_return_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
        .lb_data_out(lb_data_out), .lb_data_oe(lb_data_oe), .sync_ready_n(sync_ready_n),
        .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe), .async_ready(async_ready)
    );
    // ==========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // byte mask; unsupported patterns touch no lane
    function automatic logic [31:0] lanes32(input hbsi_lanes_t be);
        logic [31:0] m;
        m = '0;
        if (be inside {4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7})
            for (int i = 0; i < 4; i++) m[8*i +: 8] = {8{~be[i]}};
        return m;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finalReport();
        $display("checks=%0d mismatches=%0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // reset under a strap; idle outputs checked
    task automatic doReset(input logic isa);
        rst_b = 1'b0;
        bus_mode_strap_n = isa;
        PARTNER.set_mode(isa);
        repeat (16) @(posedge clk_sys);
        check({sync_ready_n, async_ready, local_device_sel_n, lb_data_oe, isa_data_oe}, 9'h1C0);
        #1;
        rst_b = 1'b1;
        repeat (12) @(posedge clk_sys);
    endtask
    // ==========
    // main sequence: local bus, then strobe bus
    initial begin
        logic [15:1] a;
        logic [31:0] m;
        logic [15:0] m16;
        logic [1:0]  w, ln;
        logic        h, qn;
        hbsi_lanes_t be;
        seed = 32'hD4222740;
        PARTNER.set_mode(1'b0);
        doReset(1'b0);
        // fill words, then mixed lanes, a miss, a bad pattern
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            be = (i < 4) ? 4'h0 : pats[i % 8];
            w = (i < 4) ? 2'(i) : seed[1:0];
            qn = (i == 13);
            a = {BASE, w, 1'b0};
            m = qn ? 32'h0 : lanes32(be);
            PARTNER.lb_cycle(a, be, 1'b1, qn, seed, rd32, oe4, ok);
            check(32'(ok), 32'(m != 32'h0));
            if (ok !== (m != 32'h0))
                finalReport();
            shadow[w] = (shadow[w] & ~m) | (seed & m);
            PARTNER.lb_cycle(a, be, 1'b0, qn, ~seed, rd32, oe4, ok);
            check(32'(oe4), 32'(~be & {4{m != 32'h0}}));
            check(rd32 & m, shadow[w] & m);
        end
        doReset(1'b1);
        // strobe bus: fill halves, then random ones
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            ln = (i < 8) ? 2'h0 : ipats[i % 3];
            w = (i < 8) ? 2'(i >> 1) : seed[17:16];
            h = (i < 8) ? i[0] : seed[18];
            qn = (i == 12);
            a = {BASE, w, h};
            m16 = qn ? 16'h0 : {{8{~ln[1]}}, {8{~ln[0]}}};
            PARTNER.isa_cycle(a, ln, 1'b1, qn, seed[15:0], rd16, oe2, ok);
            check(32'(ok), 32'h0);
            shadow[w][16*h +: 16] = (shadow[w][16*h +: 16] & ~m16) | (seed[15:0] & m16);
            PARTNER.isa_cycle(a, ln, 1'b0, qn, ~seed[15:0], rd16, oe2, ok);
            check(32'(ok), 32'(!qn));
            check(32'(oe2), 32'(~ln & {2{~qn}}));
            check(32'(rd16 & m16), 32'(shadow[w][16*h +: 16] & m16));
        end
        finalReport();
    end
endmodule // hbsi_host_port_tb_top
`default_nettype wire
